// *** src/rpc_defs.vh ***
// Purpose: Constants for the receive payload control block
// Assumes: 100 MHz core_clk
// Notes:   Offsets are direct register addresses on the host port
`ifndef RPC_DEFS_VH
`define RPC_DEFS_VH
`define RPC_OFF_CONFIG      7'h50
`define RPC_OFF_STATUS      7'h51
`define RPC_OFF_ADDR_CTRL   7'h52
`define RPC_OFF_DATA_BUF    7'h53
`define RPC_CFG_ENABLE_BIT  0
`define RPC_STAT_BUSY_BIT   7
`define RPC_AC_DIR_BIT      7
`define RPC_RESET_BYTE      8'h00
`define RPC_IND_FIRST       7'h01
`define RPC_IND_CFG_LAST    7'h18
`define RPC_IND_DTRK_FIRST  7'h19
`define RPC_IND_DTRK_LAST   7'h30
`define RPC_IND_SIG_FIRST   7'h31
`define RPC_IND_LAST        7'h48
`define RPC_CH_INVERT       7
`define RPC_CH_DTRK_EN      6
`define RPC_CH_MW_EN        5
`define RPC_CH_MSB_FLIP     4
`define RPC_CH_TEST         3
`define RPC_CH_EXTRACT      2
`define RPC_CH_FIX          1
`define RPC_CH_FORCE_VAL    0
`define RPC_SIG_TRUNK_BIT   7
`define RPC_CYCLE_NS        640
`define RPC_CLK_NS          10
`define RPC_CYCLE_CNT       ((`RPC_CYCLE_NS + `RPC_CLK_NS - 1) / `RPC_CLK_NS)
`define RPC_CYCLE_LAST      7'h3F
`endif

// *** src/rpc_mem.v ***
// Purpose: 128-byte indirect register store, registered read
// Assumes: One access per clock
// Notes:   Contents are undefined after reset, as the indirect space has no default
`default_nettype none
module rpc_mem (
  // Clock
  input  wire       core_clk,
  input  wire       clk_en,
  // Access
  input  wire       wr_en,
  input  wire [6:0] addr,
  input  wire [7:0] wdata,
  output reg  [7:0] rdata
);
  reg [7:0] store [0:127];
  always @(posedge core_clk) begin
    if (clk_en) begin
      if (wr_en) begin
        store[addr] <= wdata;
      end
      rdata <= store[addr];
    end
  end
endmodule // rpc_mem
`default_nettype wire

// *** src/rpc_buf2.v ***
// Purpose: Two-entry skid buffer for conditioned channel words
// Assumes: Same clock on both sides
// Notes:   Full at two entries, in_ready low then
`default_nettype none
module rpc_buf2 (
  // Clock and reset
  input  wire        core_clk,
  input  wire        rst_b,
  input  wire        clk_en,
  // Fill side
  input  wire        in_valid,
  output wire        in_ready,
  input  wire [12:0] in_data,
  // Drain side
  output wire        out_valid,
  input  wire        out_ready,
  output wire [12:0] out_data
);
  reg [12:0] ent0;
  reg [12:0] ent1;
  reg [1:0]  count;
  wire push;
  wire pop;
  assign in_ready  = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_data  = ent0;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  always @(posedge core_clk) begin
    if (!rst_b) begin
      count <= 2'h0;
      ent0  <= 13'h0000;
      ent1  <= 13'h0000;
    end else if (clk_en) begin
      if (pop) begin
        ent0 <= (count == 2'h2) ? ent1 : in_data;
      end else if (push && count == 2'h0) begin
        ent0 <= in_data;
      end
      if (push && ((count == 2'h1 && !pop) || (count == 2'h2 && pop))) begin
        ent1 <= in_data;
      end
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule // rpc_buf2
`default_nettype wire

// *** src/rpc_top.v ***
// Purpose: Receive payload per-channel conditioning with indirect register access
// Assumes: Channel words arrive from framer logic on core_clk; host bus is synchronous
// Notes:   One word per channel slot; outputs are registered
`include "rpc_defs.vh"
`default_nettype none
module rpc_top (
  // Clock and reset
  input  wire       core_clk,
  input  wire       rst_b,
  input  wire       clk_en,
  // Host register port
  input  wire       host_cs,
  input  wire       host_wr,
  input  wire       host_rd,
  input  wire [6:0] host_addr,
  input  wire [7:0] host_wdata,
  output reg  [7:0] host_rdata,
  // Global controls
  input  wire       pattern_direction_select,
  input  wire       frac_slave_mode,
  // Received channel stream
  input  wire       ch_valid,
  output reg        ch_ready,
  input  wire [4:0] ch_index,
  input  wire [7:0] ch_data,
  input  wire [3:0] ch_sig,
  input  wire       ch_sig_frame,
  // Pattern generator and detector
  input  wire       prbs_gen_bit,
  output reg        prbs_det_bit,
  output reg        prbs_det_valid,
  output reg        prbs_gen_take,
  // Conditioned outputs
  output reg        out_valid,
  input  wire       out_ready,
  output reg  [7:0] rx_serial_data_out,
  output reg  [3:0] rx_signaling_out,
  output reg        rx_side_clock
);
  // ==========================================================
  // Direct registers
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_RUN  = 2'h1;
  localparam [1:0] ST_DONE = 2'h2;
  localparam [1:0] ST_WAIT = 2'h3;
  localparam [6:0] CYC_LAST = `RPC_CYCLE_LAST;

  reg  [7:0] payload_ctrl_config;
  reg  [7:0] indirect_addr_control;
  reg  [7:0] indirect_data_buffer;
  reg        busy;
  reg  [1:0] state;
  reg  [6:0] cyc_cnt;
  reg  [7:0] next_rdata;

  function addr_valid;
    input [6:0] a;
    begin
      addr_valid = (a >= `RPC_IND_FIRST) && (a <= `RPC_IND_LAST);
    end
  endfunction

  function [6:0] slot_addr;
    input [6:0] base;
    input [4:0] idx;
    begin
      slot_addr = base + {2'h0, idx};
    end
  endfunction

  wire host_wr_hit = host_cs & host_wr;
  wire start_acc   = host_wr_hit && (host_addr == `RPC_OFF_ADDR_CTRL) && !busy
                     && addr_valid(host_wdata[6:0]);
  wire acc_is_rd   = indirect_addr_control[`RPC_AC_DIR_BIT];

  always @* begin
    case (host_addr)
      `RPC_OFF_CONFIG:    next_rdata = {7'h00, payload_ctrl_config[`RPC_CFG_ENABLE_BIT]};
      `RPC_OFF_STATUS:    next_rdata = {busy, 7'h00};
      `RPC_OFF_ADDR_CTRL: next_rdata = indirect_addr_control;
      `RPC_OFF_DATA_BUF:  next_rdata = indirect_data_buffer;
      default:            next_rdata = 8'h00;
    endcase
  end

  // ==========================================================
  // Indirect access engine
  // The store is single ported; channel lookups pause during the host access.
  reg        mem_wr;
  reg  [6:0] mem_addr;
  reg  [7:0] mem_wdata;
  wire [7:0] mem_rdata;
  reg  [1:0] look_phase;

  rpc_mem u_mem (
    .core_clk (core_clk),
    .clk_en   (clk_en),
    .wr_en    (mem_wr),
    .addr     (mem_addr),
    .wdata    (mem_wdata),
    .rdata    (mem_rdata)
  );

  always @(posedge core_clk) begin
    if (!rst_b) begin
      payload_ctrl_config   <= `RPC_RESET_BYTE;
      indirect_addr_control <= `RPC_RESET_BYTE;
      indirect_data_buffer  <= `RPC_RESET_BYTE;
      host_rdata            <= 8'h00;
      busy                  <= 1'b0;
      state                 <= ST_IDLE;
      cyc_cnt               <= 7'h00;
    end else if (clk_en) begin
      if (host_cs && host_rd) begin
        host_rdata <= next_rdata;
      end
      if (host_wr_hit && host_addr == `RPC_OFF_CONFIG) begin
        payload_ctrl_config <= {7'h00, host_wdata[`RPC_CFG_ENABLE_BIT]};
      end
      // A write while busy is ignored; the host must wait
      if (host_wr_hit && host_addr == `RPC_OFF_ADDR_CTRL && !busy) begin
        indirect_addr_control <= host_wdata;
      end
      if (host_wr_hit && host_addr == `RPC_OFF_DATA_BUF && !busy) begin
        indirect_data_buffer <= host_wdata;
      end
      case (state)
        ST_IDLE: begin
          if (start_acc) begin
            busy    <= 1'b1;
            cyc_cnt <= 7'h00;
            state   <= ST_WAIT;
          end
        end
        // A lookup in flight finishes first; the wait counts toward the cycle
        ST_WAIT: begin
          cyc_cnt <= cyc_cnt + 7'h01;
          if (look_phase == 2'h0) begin
            state <= ST_RUN;
          end
        end
        ST_RUN: begin
          cyc_cnt <= cyc_cnt + 7'h01;
          if (cyc_cnt == CYC_LAST - 7'h01) begin
            state <= ST_DONE;
          end
        end
        ST_DONE: begin
          if (acc_is_rd) begin
            indirect_data_buffer <= mem_rdata;
          end
          busy  <= 1'b0;
          state <= ST_IDLE;
        end
        default: begin
          busy  <= 1'b0;
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Channel lookup: config, trunk byte, signaling byte in turn
  wire host_slot = (state == ST_RUN) || (state == ST_DONE);
  reg  [7:0] cfg_q;
  reg  [7:0] dtrk_q;
  reg  [4:0] idx_q;
  reg  [7:0] dat_q;
  reg  [3:0] sig_q;
  reg        sfr_q;
  wire       buf_in_ready;
  reg        word_valid;
  reg  [12:0] word_data;

  always @* begin
    mem_wr    = 1'b0;
    mem_wdata = indirect_data_buffer;
    mem_addr  = indirect_addr_control[6:0];
    if (host_slot) begin
      mem_wr = (state == ST_DONE) && !acc_is_rd;
    end else begin
      case (look_phase)
        2'h0:    mem_addr = slot_addr(`RPC_IND_FIRST, ch_index);
        2'h1:    mem_addr = slot_addr(`RPC_IND_DTRK_FIRST, idx_q);
        2'h2:    mem_addr = slot_addr(`RPC_IND_SIG_FIRST, idx_q);
        default: mem_addr = slot_addr(`RPC_IND_FIRST, idx_q);
      endcase
    end
  end

  // Milliwatt byte sequence, eight bytes per period
  reg  [2:0] mw_step;
  function [7:0] mw_byte;
    input [2:0] s;
    begin
      case (s)
        3'h0:    mw_byte = 8'h1E;
        3'h1:    mw_byte = 8'h0B;
        3'h2:    mw_byte = 8'h0B;
        3'h3:    mw_byte = 8'h1E;
        3'h4:    mw_byte = 8'h9E;
        3'h5:    mw_byte = 8'h8B;
        3'h6:    mw_byte = 8'h8B;
        default: mw_byte = 8'h9E;
      endcase
    end
  endfunction

  // Conditioning of one channel word; bit 0 carries signaling in signaling frames
  reg  [7:0] cond;
  reg  [3:0] sig_out;
  wire       pcc_on = payload_ctrl_config[`RPC_CFG_ENABLE_BIT];
  wire [7:0] gen_byte;
  reg  [7:0] gen_shift;
  reg  [3:0] gen_cnt;
  reg  [2:0] det_cnt;
  reg  [7:0] det_shift;
  wire       is_test = pcc_on & cfg_q[`RPC_CH_TEST];
  wire       do_ext  = is_test & ~pattern_direction_select;
  wire       do_gen  = is_test &  pattern_direction_select;
  assign gen_byte = gen_shift;

  always @* begin
    cond    = dat_q;
    sig_out = sig_q;
    if (pcc_on) begin
      if (do_ext) begin
        cond = dat_q; // extraction leaves the data untouched
      end else if (cfg_q[`RPC_CH_DTRK_EN]) begin
        cond = dtrk_q;
      end else if (cfg_q[`RPC_CH_MW_EN]) begin
        cond = mw_byte(mw_step);
      end else if (do_gen) begin
        cond = gen_byte;
      end else begin
        case ({cfg_q[`RPC_CH_INVERT], cfg_q[`RPC_CH_MSB_FLIP]})
          2'b01:   cond = dat_q ^ 8'h80;
          2'b10:   cond = ~dat_q;
          2'b11:   cond = dat_q ^ 8'h7F;
          default: cond = dat_q;
        endcase
        if (cfg_q[`RPC_CH_FIX] && sfr_q) begin
          cond[0] = cfg_q[`RPC_CH_FORCE_VAL];
        end
      end
      if (mem_rdata[`RPC_SIG_TRUNK_BIT]) begin
        sig_out = mem_rdata[3:0];
      end
    end
  end

  // ==========================================================
  // Lookup sequencing and test-pattern stream
  wire take_in = ch_valid && ch_ready;
  always @(posedge core_clk) begin
    if (!rst_b) begin
      look_phase     <= 2'h0;
      ch_ready       <= 1'b0;
      cfg_q          <= 8'h00;
      dtrk_q         <= 8'h00;
      idx_q          <= 5'h00;
      dat_q          <= 8'h00;
      sig_q          <= 4'h0;
      sfr_q          <= 1'b0;
      word_valid     <= 1'b0;
      word_data      <= 13'h0000;
      mw_step        <= 3'h0;
      gen_shift      <= 8'h00;
      gen_cnt        <= 4'h0;
      prbs_gen_take  <= 1'b0;
      prbs_det_bit   <= 1'b0;
      prbs_det_valid <= 1'b0;
      det_cnt        <= 3'h0;
      det_shift      <= 8'h00;
    end else if (clk_en) begin
      prbs_gen_take  <= 1'b0;
      prbs_det_valid <= 1'b0;
      // Generator bits are collected one per cycle into a byte
      if (pattern_direction_select && gen_cnt != 4'h8) begin
        gen_shift     <= {gen_shift[6:0], prbs_gen_bit};
        gen_cnt       <= gen_cnt + 4'h1;
        prbs_gen_take <= 1'b1;
      end
      // Extracted bytes are shifted out MSB first, eight back-to-back bits per byte with gaps between bytes
      if (det_cnt != 3'h0) begin
        prbs_det_bit   <= det_shift[7];
        prbs_det_valid <= 1'b1;
        det_shift      <= {det_shift[6:0], 1'b0};
        det_cnt        <= det_cnt + 3'h1;
      end
      if (word_valid && buf_in_ready) begin
        word_valid <= 1'b0;
      end
      ch_ready <= 1'b0;
      if (!host_slot) begin
        case (look_phase)
          2'h0: begin
            // No take while the host engine owns the store or the generator byte is short
            ch_ready <= !ch_ready && !word_valid && det_cnt == 3'h0 && !busy && !start_acc
                        && (!pattern_direction_select || gen_cnt == 4'h8);
            if (take_in) begin
              idx_q      <= ch_index;
              dat_q      <= ch_data;
              sig_q      <= ch_sig;
              sfr_q      <= ch_sig_frame;
              look_phase <= 2'h1;
            end
          end
          2'h1: begin
            cfg_q      <= mem_rdata;
            look_phase <= 2'h2;
          end
          2'h2: begin
            dtrk_q     <= mem_rdata;
            look_phase <= 2'h3;
          end
          default: begin
            word_valid <= 1'b1;
            word_data  <= {pcc_on & cfg_q[`RPC_CH_EXTRACT], sig_out, cond};
            mw_step    <= (pcc_on & cfg_q[`RPC_CH_MW_EN]) ? mw_step + 3'h1 : mw_step;
            if (do_ext) begin
              det_shift      <= {dat_q[6:0], 1'b0};
              prbs_det_bit   <= dat_q[7];
              prbs_det_valid <= 1'b1;
              det_cnt        <= 3'h1;
            end
            if (do_gen) begin
              gen_cnt <= 4'h0;
            end
            look_phase <= 2'h0;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Output buffer and registered outputs
  wire        buf_out_valid;
  wire [12:0] buf_out_data;
  wire        take_out = buf_out_valid && (!out_valid || out_ready);

  rpc_buf2 u_buf (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .clk_en    (clk_en),
    .in_valid  (word_valid),
    .in_ready  (buf_in_ready),
    .in_data   (word_data),
    .out_valid (buf_out_valid),
    .out_ready (!out_valid || out_ready),
    .out_data  (buf_out_data)
  );

  always @(posedge core_clk) begin
    if (!rst_b) begin
      out_valid          <= 1'b0;
      rx_serial_data_out <= 8'h00;
      rx_signaling_out   <= 4'h0;
      rx_side_clock      <= 1'b0;
    end else if (clk_en) begin
      if (take_out) begin
        out_valid          <= 1'b1;
        rx_serial_data_out <= buf_out_data[7:0];
        rx_signaling_out   <= buf_out_data[11:8];
        // Outside fractional slave mode the side clock runs in every channel
        rx_side_clock      <= frac_slave_mode ? buf_out_data[12] : 1'b1;
      end else if (out_ready) begin
        out_valid     <= 1'b0;
        rx_side_clock <= 1'b0;
      end
    end
  end
endmodule // rpc_top
`default_nettype wire

// *** verification/rpc_chk.sv ***
// Purpose: Port assertions for rpc_top
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound from the bench top file
`default_nettype none
module rpc_chk (
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       rst_b,
  input wire logic       clk_en,
  // Host port
  input wire logic       host_cs,
  input wire logic       host_wr,
  input wire logic       host_rd,
  input wire logic [6:0] host_addr,
  input wire logic [7:0] host_wdata,
  input wire logic [7:0] host_rdata,
  // Stream and pattern side
  input wire logic       pattern_direction_select,
  input wire logic       ch_valid,
  input wire logic       ch_ready,
  input wire logic [7:0] ch_data,
  input wire logic       prbs_det_valid,
  input wire logic       prbs_gen_take,
  input wire logic       out_valid,
  input wire logic       out_ready,
  input wire logic [7:0] rx_serial_data_out
);
  // ==========================================
  // Shadow of the enable bit and last word taken
  logic       en;
  logic [7:0] last_d;
  always_ff @(posedge core_clk) begin
    if (!rst_b)
      en <= 1'b0;
    else if (clk_en && host_cs && host_wr && host_addr == 7'h50)
      en <= host_wdata[0];
  end
  always_ff @(posedge core_clk) begin
    if (clk_en && ch_valid && ch_ready)
      last_d <= ch_data;
  end
  // ==========================================
  // Assertions
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  reset_clear_a: assert property (disable iff (1'b0) !rst_b && clk_en |=>
    !out_valid && !ch_ready && host_rdata == 8'h00) else $error("outputs not cleared");
  freeze_all_a: assert property (!clk_en |=> $stable(out_valid) && $stable(ch_ready)
    && $stable(rx_serial_data_out)) else $error("state moved while frozen");
  out_hold_a: assert property (out_valid && !out_ready |=> out_valid
    && $stable(rx_serial_data_out)) else $error("stalled word lost");
  take_gap_a: assert property (clk_en && ch_valid && ch_ready |=> !ch_ready [*3])
    else $error("words taken too close");
  rdata_hold_a: assert property (!(clk_en && host_cs && host_rd) |=> $stable(host_rdata))
    else $error("read data moved without read");
  det_run_a: assert property ($rose(prbs_det_valid) |-> prbs_det_valid [*8])
    else $error("detector run not eight bits");
  det_dir_a: assert property (prbs_det_valid |-> !pattern_direction_select)
    else $error("extraction in generator mode");
  gen_dir_a: assert property (prbs_gen_take |-> $past(pattern_direction_select)
    && !prbs_det_valid) else $error("generator used in extract mode");
  bypass_a: assert property (clk_en && ch_valid && ch_ready && !en |-> ##[5:60]
    (out_valid && rx_serial_data_out == last_d)) else $error("disabled word altered");
endmodule // rpc_chk
`default_nettype wire

// *** verification/rpc_host.sv ***
// Purpose: Host processor model for the direct register port
// Assumes: One strobe cycle per access, read data the cycle after
// Notes:   Released write data is inverted so stale values are never trusted
`default_nettype none
module rpc_host (
  // Clock
  input  wire logic       core_clk,
  // Register port
  output var  logic       host_cs,
  output var  logic       host_wr,
  output var  logic       host_rd,
  output var  logic [6:0] host_addr,
  output var  logic [7:0] host_wdata,
  input  wire logic [7:0] host_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {host_cs, host_wr, host_rd, host_addr, host_wdata} = '0;
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge core_clk);
    {host_cs, host_wr, host_addr, host_wdata} <= {2'b11, a, d};
    @(posedge core_clk);
    {host_cs, host_wr, host_wdata} <= {2'b00, ~d};
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge core_clk);
    {host_cs, host_rd, host_addr} <= {2'b11, a};
    @(posedge core_clk);
    {host_cs, host_rd} <= 2'b00;
    @(posedge core_clk);
    #1 d = host_rdata;
  endtask
  // Polls busy; each poll is three cycles, so n counts cycles
  task automatic idle(output int n);
    logic [7:0] s;
    n = 0;
    do begin
      rd(7'h51, s);
      n += 3;
    end while (s[7] !== 1'b0 && n < 300);
  endtask
  task automatic ind_wr(input logic [6:0] a, input logic [7:0] d);
    int n;
    wr(7'h53, d);
    wr(7'h52, {1'b0, a});
    idle(n);
  endtask
  task automatic ind_rd(input logic [6:0] a, output logic [7:0] d);
    int n;
    wr(7'h52, {1'b1, a});
    idle(n);
    rd(7'h53, d);
  endtask
endmodule // rpc_host
`default_nettype wire

// *** verification/tb_rpc_top.sv ***
// Purpose: Self-checking bench for rpc_top
// Assumes: Host model owns the register port
// Notes:   Indirect store is programmed before each conditioning check
`default_nettype none
module tb_rpc_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 0, rst_b = 0, clk_en = 1, pattern_direction_select = 0;
  logic frac_slave_mode = 0, prbs_gen_bit = 0, ch_valid = 0, ch_sig_frame = 0;
  logic out_ready = 1, host_cs, host_wr, host_rd, ch_ready, prbs_det_bit;
  logic prbs_det_valid, prbs_gen_take, out_valid, rx_side_clock;
  logic [6:0]  host_addr;
  logic [7:0]  host_wdata, host_rdata, rx_serial_data_out, v;
  logic [4:0]  ch_index = 0;
  logic [7:0]  ch_data = 0;
  logic [3:0]  ch_sig = 0, rx_signaling_out;
  logic [15:0] det_sh = 0;
  logic [12:0] o;
  int          det_n = 0, miscompares = 0, num_checks = 0, n;
  always #5 core_clk = ~core_clk;
  rpc_top dut (.*);
  rpc_host host (.*);
  // Collect the extracted test stream
  always @(posedge core_clk) begin
    if (prbs_det_valid === 1'b1) begin
      det_sh <= {det_sh[14:0], prbs_det_bit};
      det_n <= det_n + 1;
    end
  end
  // ==========================================
  // Shared tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results;
    $display("checks=%0d mismatches=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic put(input logic [4:0] c, input logic [7:0] d, input logic [3:0] s,
                     input logic f, output logic ok);
    int k;
    @(posedge core_clk);
    {ch_valid, ch_index, ch_data, ch_sig, ch_sig_frame} <= {1'b1, c, d, s, f};
    k = 0;
    do @(negedge core_clk); while (ch_ready !== 1'b1 && ++k < 100);
    ok = (ch_ready === 1'b1);
    @(posedge core_clk);
    {ch_valid, ch_data} <= {1'b0, ~d};
  endtask
  task automatic take(output logic [12:0] r);
    int k;
    k = 0;
    do @(negedge core_clk); while (out_valid !== 1'b1 && ++k < 100);
    r = {rx_serial_data_out, rx_signaling_out, rx_side_clock};
    @(posedge core_clk);
  endtask
  // Result is {data, signaling, side clock}
  task automatic xfer(input logic [4:0] c, input logic [7:0] d, input logic [3:0] s,
                      input logic f);
    logic ok;
    put(c, d, s, f, ok);
    take(o);
  endtask
  // ==========================================
  // Scenarios
  task automatic t_regs;
    for (int a = 'h50; a <= 'h54; a++) begin
      host.rd(7'(a), v);
      check(v, 8'h00);
    end
    host.wr(7'h51, 8'hFF);
    host.rd(7'h51, v);
    check(v, 8'h00);
    host.wr(7'h50, 8'h01);
    host.rd(7'h50, v);
    check(v, 8'h01);
    host.wr(7'h50, 8'h00);
  endtask
  task automatic t_ind;
    logic [6:0] ad [6] = '{7'h01, 7'h18, 7'h19, 7'h30, 7'h31, 7'h48};
    host.wr(7'h53, 8'h3C);
    host.wr(7'h52, 8'h01);
    host.idle(n);
    check(n >= 60 && n <= 72, 1'b1);
    foreach (ad[i])
      host.ind_wr(ad[i], {4'h8, ad[i][3:0]});
    foreach (ad[i]) begin
      host.ind_rd(ad[i], v);
      check(v, {4'h8, ad[i][3:0]});
    end
    host.wr(7'h53, 8'h11);
    host.wr(7'h52, 8'h49);
    host.rd(7'h51, v);
    check(v, 8'h00);
    host.wr(7'h52, 8'h00);
    host.rd(7'h51, v);
    check(v, 8'h00);
    host.ind_rd(7'h48, v);
    check(v, 8'h88);
  endtask
  task automatic t_cond;
    logic [7:0] inv [4] = '{8'h35, 8'hB5, 8'hCA, 8'h4A};
    host.ind_wr(7'h01, 8'h80);
    xfer(0, 8'h35, 4'h5, 1'b0);
    check(o[12:1], 12'h355);
    host.wr(7'h50, 8'h01);
    for (int k = 0; k < 4; k++) begin
      host.ind_wr(7'h01, {k[1], 2'b00, k[0], 4'h0});
      xfer(0, 8'h35, 4'h5, 1'b0);
      check(o[12:5], inv[k]);
    end
    host.ind_wr(7'h18, 8'hE0);
    host.ind_wr(7'h30, 8'h5A);
    xfer(23, 8'h35, 4'h5, 1'b0);
    check(o[12:5], 8'h5A);
    host.ind_wr(7'h18, 8'h20);
    xfer(23, 8'h35, 4'h5, 1'b0);
    check(o[12:5] inside {8'h1E, 8'h0B, 8'h9E, 8'h8B}, 1'b1);
    host.ind_wr(7'h01, 8'h03);
    xfer(0, 8'h34, 4'h5, 1'b1);
    check(o[12:5], 8'h35);
    host.ind_wr(7'h01, 8'h82);
    xfer(0, 8'h34, 4'h5, 1'b1);
    check(o[12:5], 8'hCA);
    host.ind_wr(7'h31, 8'h8A);
    xfer(0, 8'h34, 4'h5, 1'b0);
    check(o[4:1], 4'hA);
    host.ind_wr(7'h31, 8'h0A);
    xfer(0, 8'h34, 4'h5, 1'b0);
    check(o[4:1], 4'h5);
    frac_slave_mode <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      host.ind_wr(7'h01, {5'h00, k[0], 2'b00});
      xfer(0, 8'h34, 4'h5, 1'b0);
      check(o[0], k[0]);
    end
    frac_slave_mode <= 1'b0;
  endtask
  task automatic t_test;
    int k;
    host.ind_wr(7'h01, 8'h08);
    host.ind_wr(7'h02, 8'h08);
    n = det_n;
    xfer(0, 8'hA5, 4'h5, 1'b0);
    check(o[12:5], 8'hA5);
    xfer(1, 8'h3C, 4'h5, 1'b0);
    k = 0;
    while (det_n < n + 16 && k++ < 100)
      @(posedge core_clk);
    check(det_sh, 16'hA53C);
    pattern_direction_select <= 1'b1;
    prbs_gen_bit <= 1'b1;
    host.ind_wr(7'h01, 8'h88);
    xfer(0, 8'h35, 4'h5, 1'b0);
    check(o[12:5], 8'hFF);
    pattern_direction_select <= 1'b0;
    prbs_gen_bit <= 1'b0;
  endtask
  // Fill the output path while stalled, freeze a while, then drain in order
  task automatic t_stall;
    logic ok;
    host.ind_wr(7'h01, 8'h00);
    out_ready <= 1'b0;
    n = 0;
    do begin
      put(0, 8'(8'h10 + n), 4'h0, 1'b0, ok);
      n += ok;
    end while (ok && n < 8);
    clk_en <= 1'b0;
    repeat (4) @(posedge core_clk);
    clk_en <= 1'b1;
    out_ready <= 1'b1;
    check(n >= 2, 1'b1);
    for (int i = 0; i < n; i++) begin
      take(o);
      check(o[12:5], 8'(8'h10 + i));
    end
  endtask
  // ==========================================
  // Main sequence and watchdog
  initial begin
    repeat (16) @(posedge core_clk);
    rst_b <= 1'b1;
    t_regs;
    t_ind;
    t_cond;
    t_test;
    t_stall;
    results;
  end
  initial begin
    #500us;
    miscompares++;
    results;
  end
endmodule // tb_rpc_top
bind rpc_top rpc_chk chk (.*);
`default_nettype wire
